// file: src/mbpwm_top.sv
// Match based pwm timer with a classic Wishbone register slave
// Operation
// - counter ticks clock, seven match registers
// - period match clears counter, sets cycle
// - single edge uses period plus one match
// - each extra single output adds one match
// - single outputs rise at period match
// - double edge uses period plus two matches
// - each extra double output adds two
// - rise first high pulse, fall first low
// - double edges may sit anywhere in cycle
// - six single, three double, or mixed
// - match may just flag, counter continues
// - match may halt counter, optional flag
// - match may clear counter, optional flag
// - period and width any tick count
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "mbpwm_defs.svh"

module mbpwm_top (
    input  logic                    clk_i,
    input  logic                    rst_i,
    input  mbpwm_pkg::mbpwm_wb_req_t wb_req_i,
    output mbpwm_pkg::mbpwm_wb_rsp_t wb_rsp_o,
    output logic [`MBPWM_NOUT-1:0]  pwm_o,
    output logic                    irq_o
);
    import mbpwm_pkg::*;

    localparam int NM = `MBPWM_NMATCH;
    localparam int NO = `MBPWM_NOUT;
    localparam int MW = `MBPWM_MC_W;

    mbpwm_state_t             s;
    mbpwm_state_t             next_s;

    logic                     tick;
    logic [NM-1:0]            hit;
    logic [NM-1:0]            hit_int;
    logic [NM-1:0]            hit_rst;
    logic [NM-1:0]            hit_stop;
    logic [NO-1:0]            ch_set;
    logic [NO-1:0]            ch_clr;
    logic                     access;
    logic                     wr;
    logic                     wr_count;
    logic                     wr_ctrl;
    logic                     wr_status;

    // Aligned byte address compare, shared by read and write decode
    function automatic logic reg_hit(input logic [`MBPWM_AW-1:0] adr,
                                     input logic [`MBPWM_AW-1:0] off);
        reg_hit = (adr == off);
    endfunction

    function automatic logic [`MBPWM_AW-1:0] mr_off(input int idx);
        mr_off = `MBPWM_ADR_MR_BASE + `MBPWM_AW'(idx) * `MBPWM_MR_STEP;
    endfunction

    // Byte lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

    // matches only count while the timer ticks
    assign tick      = s.en && !s.hold;

    assign access    = wb_req_i.cyc && wb_req_i.stb && !s.ack;
    assign wr        = access && wb_req_i.we;
    assign wr_count  = wr && reg_hit(wb_req_i.adr, `MBPWM_ADR_COUNT);
    assign wr_ctrl   = wr && reg_hit(wb_req_i.adr, `MBPWM_ADR_CTRL);
    assign wr_status = wr && reg_hit(wb_req_i.adr, `MBPWM_ADR_STATUS);

    // seven comparators against the one counter
    // any register value is a legal tick position
    for (genvar i = 0; i < NM; i++) begin : g_match
        mbpwm_match u_match (
            .tick_i   (tick),
            .count_i  (s.tc),
            .value_i  (s.mr[i]),
            .action_i (s.mctrl[i*MW +: MW]),
            .hit_o    (hit[i]),
            .int_o    (hit_int[i]),
            .rst_o    (hit_rst[i]),
            .stop_o   (hit_stop[i])
        );
    end

    // output k owns match k; double mode borrows match k-1
    for (genvar k = 1; k <= NO; k++) begin : g_chan
        // single edge sets on the period match
        // double edge sets on the neighbouring match
        assign ch_set[k-1] = s.dbl[k-1] && k > 1 ? hit[k-1] : hit[0];
        // a double output pairs match k-1 and k
        assign ch_clr[k-1] = hit[k];

        // order of set and clear picks pulse polarity
        // in double mode both edges are free within the cycle; single outputs set on the period match
        mbpwm_chan u_chan (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .en_i  (s.out_en[k-1]),
            .set_i (ch_set[k-1]),
            .clr_i (ch_clr[k-1]),
            .pwm_o (pwm_o[k-1])
        );
    end

    always_comb begin
        logic [31:0] rd;
        logic [31:0] cur;
        rd  = 32'h0;
        cur = 32'h0;
        next_s = s;

        // Counter and match actions
        if (s.hold) begin
            next_s.tc = '0;
        end else if (tick) begin
            // period match clears via its reset action
            // any reset match clears the count
            if (|hit_rst) begin
                next_s.tc = '0;
            end else begin
                // a plain match lets counting continue
                next_s.tc = s.tc + `MBPWM_CW'(1);
            end
        end
        // stop match drops the enable, count is kept
        if (|hit_stop) begin
            next_s.en = 1'b0;
        end

        // Software writes take effect at the edge that raises ack
        if (wr) begin
            if (reg_hit(wb_req_i.adr, `MBPWM_ADR_CTRL)) begin
                cur = lane_merge(32'h0, wb_req_i.dat, wb_req_i.sel);
                if (wb_req_i.sel[0]) begin
                    next_s.en   = cur[`MBPWM_CTRL_EN];
                    next_s.hold = cur[`MBPWM_CTRL_HOLD];
                end
            end
            if (reg_hit(wb_req_i.adr, `MBPWM_ADR_COUNT)) begin
                next_s.tc = lane_merge(s.tc, wb_req_i.dat, wb_req_i.sel);
            end
            if (reg_hit(wb_req_i.adr, `MBPWM_ADR_STATUS)) begin
                cur = lane_merge(32'h0, wb_req_i.dat, wb_req_i.sel);
                next_s.status = s.status & ~cur[NM-1:0];
            end
            if (reg_hit(wb_req_i.adr, `MBPWM_ADR_MASK)) begin
                cur = lane_merge({25'h0, s.mask}, wb_req_i.dat,
                                 wb_req_i.sel);
                next_s.mask = cur[NM-1:0];
            end
            if (reg_hit(wb_req_i.adr, `MBPWM_ADR_MCTRL)) begin
                cur = lane_merge({11'h0, s.mctrl}, wb_req_i.dat,
                                 wb_req_i.sel);
                next_s.mctrl = cur[NM*MW-1:0];
            end
            if (reg_hit(wb_req_i.adr, `MBPWM_ADR_OUTCFG)) begin
                cur = lane_merge({18'h0, s.dbl, 2'h0, s.out_en},
                                 wb_req_i.dat, wb_req_i.sel);
                next_s.out_en = cur[NO-1:0];
                next_s.dbl    = cur[`MBPWM_CFG_DBL +: NO];
            end
            for (int i = 0; i < NM; i++) begin
                if (reg_hit(wb_req_i.adr, mr_off(i))) begin
                    next_s.mr[i] = lane_merge(s.mr[i], wb_req_i.dat,
                                              wb_req_i.sel);
                end
            end
        end

        // a new event beats a clear in the same cycle
        next_s.status = next_s.status | hit_int;
        next_s.irq    = |(next_s.status & next_s.mask);

        // Read mux; unmapped addresses answer with zero
        if (reg_hit(wb_req_i.adr, `MBPWM_ADR_CTRL)) begin
            rd[`MBPWM_CTRL_EN]   = s.en;
            rd[`MBPWM_CTRL_HOLD] = s.hold;
        end
        if (reg_hit(wb_req_i.adr, `MBPWM_ADR_COUNT)) begin
            rd = s.tc;
        end
        if (reg_hit(wb_req_i.adr, `MBPWM_ADR_STATUS)) begin
            rd[NM-1:0] = s.status;
        end
        if (reg_hit(wb_req_i.adr, `MBPWM_ADR_MASK)) begin
            rd[NM-1:0] = s.mask;
        end
        if (reg_hit(wb_req_i.adr, `MBPWM_ADR_MCTRL)) begin
            rd[NM*MW-1:0] = s.mctrl;
        end
        if (reg_hit(wb_req_i.adr, `MBPWM_ADR_OUTCFG)) begin
            rd[NO-1:0]               = s.out_en;
            rd[`MBPWM_CFG_DBL +: NO] = s.dbl;
        end
        for (int i = 0; i < NM; i++) begin
            if (reg_hit(wb_req_i.adr, mr_off(i))) begin
                rd = s.mr[i];
            end
        end

        // One wait-free answer; ack drops the cycle after
        next_s.ack = access;
        if (access && !wb_req_i.we) begin
            next_s.rdat = rd;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            // Period match clears the count from reset onward
            s.mctrl <= `MBPWM_MCTRL_RV;
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp_o.ack = s.ack;
    assign wb_rsp_o.dat = s.rdat;
    assign irq_o        = s.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence plain_tick_s;
        tick && !(|hit_rst) && !wr_count;
    endsequence

    sequence period_hit_s;
        tick && hit[0] && s.mctrl[`MBPWM_MC_RST] && !wr_count;
    endsequence

    count_step_a: assert property (
        plain_tick_s |=> s.tc == $past(s.tc) + `MBPWM_CW'(1))
        else $error("counter did not advance by one");

    period_clear_a: assert property (
        period_hit_s |=> s.tc == '0)
        else $error("period match did not clear the counter");

    any_clear_a: assert property (
        tick && (|hit_rst) && !wr_count |=> s.tc == '0)
        else $error("reset match did not clear the counter");

    stop_halt_a: assert property (
        (|hit_stop) && !wr_ctrl |=> !s.en ##1 $stable(s.tc))
        else $error("stop match did not halt the counter");

    flag_set_a: assert property (
        hit_int[1] |=> s.status[1] ##1 (s.status[1] || $past(wr_status)))
        else $error("match interrupt flag not set or not sticky");

    irq_level_a: assert property (
        irq_o == |(s.status & s.mask))
        else $error("unmasked flag did not raise the interrupt");

    single_rise_a: assert property (
        tick && hit[0] && !hit[1] && s.out_en[0] |=> pwm_o[0])
        else $error("single edge output did not rise at period match");

    dbl_pulse_a: assert property (
        tick && s.dbl[4] && s.out_en[4] && hit[4] && !hit[5]
        |=> pwm_o[4])
        else $error("double edge output did not rise on its set match");

    bus_ack_a: assert property (
        wb_req_i.cyc && wb_req_i.stb && !s.ack |=> s.ack ##1 !s.ack)
        else $error("bus answer not given for exactly one cycle");

    // Checks below look one edge after their cause, as all state is
    // registered; write checks cover full four lane writes, except the control check, which needs only lane 0

    ack_cause_a: assert property (
        s.ack |-> $past(access))
        else $error("bus answer given without a request");

    read_count_a: assert property (
        access && !wb_req_i.we && reg_hit(wb_req_i.adr, `MBPWM_ADR_COUNT)
        |=> wb_rsp_o.dat == $past(s.tc))
        else $error("count read returned a stale value");

    hold_zero_a: assert property (
        s.hold && !wr_count |=> s.tc == '0)
        else $error("held counter did not read zero");

    count_load_a: assert property (
        wr_count && (&wb_req_i.sel) |=> s.tc == $past(wb_req_i.dat))
        else $error("counter load did not land");

    ctrl_win_a: assert property (
        wr_ctrl && wb_req_i.sel[0]
        |=> s.en == $past(wb_req_i.dat[`MBPWM_CTRL_EN]))
        else $error("control write did not set the enable");

    mask_write_a: assert property (
        wr && reg_hit(wb_req_i.adr, `MBPWM_ADR_MASK) && (&wb_req_i.sel)
        |=> s.mask == $past(wb_req_i.dat[NM-1:0]))
        else $error("mask write did not land");

    flag_clear_a: assert property (
        wr_status && (&wb_req_i.sel) && !(|hit_int)
        |=> (s.status & $past(wb_req_i.dat[NM-1:0])) == '0)
        else $error("status flag not cleared by a one");

    neg_pulse_a: assert property (
        tick && s.dbl[5] && s.out_en[5] && hit[5] && !hit[6]
        |=> pwm_o[5])
        else $error("low going pulse did not end on its set match");

    for (genvar k = 0; k < NO; k++) begin : g_chk
        out_off_a: assert property (
            !s.out_en[k] |=> !pwm_o[k])
            else $error("disabled output did not stay low");

        edge_fall_a: assert property (
            tick && s.out_en[k] && hit[k + 1] |=> !pwm_o[k])
            else $error("output did not fall at its edge match");
    end

    for (genvar i = 0; i < NM; i++) begin : g_mr_chk
        mr_load_a: assert property (
            wr && reg_hit(wb_req_i.adr, mr_off(i)) && (&wb_req_i.sel)
            |=> s.mr[i] == $past(wb_req_i.dat))
            else $error("match register write did not land");
    end

endmodule

// file: src/mbpwm_defs.svh
// Constants shared by the match based pwm timer design files
`ifndef MBPWM_DEFS_SVH
`define MBPWM_DEFS_SVH

`define MBPWM_CW          32
`define MBPWM_NMATCH      7
`define MBPWM_NOUT        6
`define MBPWM_AW          8

`define MBPWM_ADR_CTRL    8'h00
`define MBPWM_ADR_COUNT   8'h04
`define MBPWM_ADR_STATUS  8'h08
`define MBPWM_ADR_MASK    8'h0C
`define MBPWM_ADR_MCTRL   8'h10
`define MBPWM_ADR_OUTCFG  8'h14
`define MBPWM_ADR_MR_BASE 8'h20
`define MBPWM_MR_STEP     8'h04

`define MBPWM_CTRL_EN     0
`define MBPWM_CTRL_HOLD   1

`define MBPWM_MC_W        3
`define MBPWM_MC_INT      0
`define MBPWM_MC_RST      1
`define MBPWM_MC_STOP     2
`define MBPWM_MCTRL_RV    21'h000002

`define MBPWM_CFG_DBL     8

`endif

// file: src/mbpwm_pkg.sv
// Types shared by the match based pwm timer design files
`include "mbpwm_defs.svh"

package mbpwm_pkg;

    typedef struct packed {
        logic                   cyc;
        logic                   stb;
        logic                   we;
        logic [3:0]             sel;
        logic [`MBPWM_AW-1:0]   adr;
        logic [31:0]            dat;
    } mbpwm_wb_req_t;

    typedef struct packed {
        logic                   ack;
        logic [31:0]            dat;
    } mbpwm_wb_rsp_t;

    typedef struct packed {
        logic [`MBPWM_NMATCH-1:0][`MBPWM_CW-1:0] mr;
        logic [`MBPWM_CW-1:0]                    tc;
        logic                                    en;
        logic                                    hold;
        logic [`MBPWM_NMATCH-1:0]                status;
        logic [`MBPWM_NMATCH-1:0]                mask;
        logic [`MBPWM_NMATCH*`MBPWM_MC_W-1:0]    mctrl;
        logic [`MBPWM_NOUT-1:0]                  out_en;
        logic [`MBPWM_NOUT-1:0]                  dbl;
        logic                                    irq;
        logic                                    ack;
        logic [31:0]                             rdat;
    } mbpwm_state_t;

    typedef struct packed {
        logic                   q;
    } mbpwm_chan_t;

endpackage

// file: src/mbpwm_match.sv
// One match comparator with its action decode
`timescale 1ns/10ps
`include "mbpwm_defs.svh"

module mbpwm_match (
    input  logic                    tick_i,
    input  logic [`MBPWM_CW-1:0]    count_i,
    input  logic [`MBPWM_CW-1:0]    value_i,
    input  logic [`MBPWM_MC_W-1:0]  action_i,
    output logic                    hit_o,
    output logic                    int_o,
    output logic                    rst_o,
    output logic                    stop_o
);
    import mbpwm_pkg::*;

    assign hit_o  = tick_i && (count_i == value_i);
    assign int_o  = hit_o && action_i[`MBPWM_MC_INT];
    assign rst_o  = hit_o && action_i[`MBPWM_MC_RST];
    assign stop_o = hit_o && action_i[`MBPWM_MC_STOP];

endmodule

// file: src/mbpwm_chan.sv
// One pwm output stage driven by a set and a clear event
`timescale 1ns/10ps

module mbpwm_chan (
    input  logic    clk_i,
    input  logic    rst_i,
    input  logic    en_i,
    input  logic    set_i,
    input  logic    clr_i,
    output logic    pwm_o
);
    import mbpwm_pkg::*;

    mbpwm_chan_t s;
    mbpwm_chan_t next_s;

    always_comb begin
        next_s = s;
        if (!en_i) begin
            next_s.q = 1'b0;
        end else if (clr_i) begin
            // Clear wins so an edge value equal to the set match gives a constant low
            next_s.q = 1'b0;
        end else if (set_i) begin
            next_s.q = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pwm_o = s.q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chan_rise_a: assert property (
        en_i && set_i && !clr_i |=> pwm_o)
        else $error("output did not rise on its set event");

    chan_fall_a: assert property (
        clr_i |=> !pwm_o)
        else $error("output did not fall on its clear event");

endmodule

// file: test/mbpwm_load.sv
// Passive load model that times the high phase and period of each output
`timescale 1ns/10ps

module mbpwm_load (
    input  logic             clk_i,
    input  logic             rst_i,
    input  logic [5:0]       pwm_i,
    output logic [5:0][15:0] per_o,
    output logic [5:0][15:0] wid_o,
    output logic [5:0][7:0]  rise_o
);
    logic [5:0]       last;
    logic [5:0][15:0] age;

    // Loads only listen; a motor driver never answers back
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 6; k++) begin
            if (rst_i) begin
                last[k]   <= 1'b0;
                age[k]    <= 16'h0000;
                per_o[k]  <= 16'h0000;
                wid_o[k]  <= 16'h0000;
                rise_o[k] <= 8'h00;
            end else begin
                last[k] <= pwm_i[k];
                age[k]  <= age[k] + 16'h0001;
                if (pwm_i[k] && !last[k]) begin
                    age[k]    <= 16'h0001;
                    per_o[k]  <= age[k];
                    rise_o[k] <= rise_o[k] + 8'h01;
                end
                if (!pwm_i[k] && last[k]) begin
                    wid_o[k] <= age[k];
                end
            end
        end
    end
endmodule

// file: test/mbpwm_tb_top.sv
// Self-checking bench for the match based pwm timer
`timescale 1ns/10ps
`include "mbpwm_defs.svh"

module mbpwm_tb_top;
    import mbpwm_pkg::*;

    localparam int PER = 10;
    // Match values: period 9; ch2 disabled stays low, ch3 edge past period
    localparam int MRV [7] = '{9, 3, 0, 20, 2, 7, 4};

    logic             clk_i;
    logic             rst_i;
    mbpwm_wb_req_t    req;
    mbpwm_wb_rsp_t    rsp;
    logic [5:0]       pwm;
    logic             irq;
    logic [5:0][15:0] per;
    logic [5:0][15:0] wid;
    logic [5:0][7:0]  rises;
    logic [31:0]      rd;
    logic [31:0]      rd2;
    int               fails;
    int               cmp_count;
    int               cycles;

    mbpwm_top DUT (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_req_i (req),
        .wb_rsp_o (rsp),
        .pwm_o    (pwm),
        .irq_o    (irq)
    );

    mbpwm_load LOAD (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pwm_i  (pwm),
        .per_o  (per),
        .wid_o  (wid),
        .rise_o (rises)
    );

    always #2 clk_i = ~clk_i;

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Classic single cycle; the wait is bounded only by the bench timeout
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat, output logic [31:0] q);
        @(posedge clk_i);
        req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:adr, dat:dat};
        do begin
            @(posedge clk_i);
        end while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb(1'b1, adr, dat, rd2);
    endtask

    task automatic rdc(input string name, input logic [7:0] adr,
                       input logic [31:0] exp);
        wb(1'b0, adr, 32'h00000000, rd);
        check(name, rd, exp);
    endtask

    // High phase runs from the count after the set match to the clear match
    function automatic int width(input int s, input int c);
        return (c + PER - s) % PER;
    endfunction

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        int s;
        clk_i = 1'b0;
        rst_i = 1'b1;
        req = '0;
        fails = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("pwm_rst", {26'h0, pwm}, 32'h0);
        rdc("mctrl_rst", `MBPWM_ADR_MCTRL, 32'h00000002);
        rdc("ctrl_rst", `MBPWM_ADR_CTRL, 32'h00000000);
        rdc("unmapped", 8'h40, 32'h00000000);
        for (int i = 0; i < 7; i++) begin
            wr(8'(`MBPWM_ADR_MR_BASE + 4 * i), MRV[i]);
        end
        rdc("mr6", 8'h38, 32'h00000004);
        wr(`MBPWM_ADR_OUTCFG, 32'h0000303D);
        wr(`MBPWM_ADR_MCTRL, 32'h0000000A);
        wr(`MBPWM_ADR_MASK, 32'h00000002);
        wr(`MBPWM_ADR_CTRL, 32'h00000001);
        repeat (60) @(posedge clk_i);
        for (int k = 0; k < 6; k++) begin
            if (k == 1 || k == 2) begin
                continue;
            end
            s = (k >= 4) ? MRV[k] : MRV[0];
            check("period", per[k], PER);
            check("width", wid[k], width(s, MRV[k + 1]));
        end
        check("ch2_low", {31'h0, pwm[1]}, 32'h0);
        check("ch2_rises", rises[1], 32'h0);
        check("ch3_high", {31'h0, pwm[2]}, 32'h1);
        check("irq_run", {31'h0, irq}, 32'h1);
        wr(`MBPWM_ADR_CTRL, 32'h00000000);
        rdc("status", `MBPWM_ADR_STATUS, 32'h00000002);
        wr(`MBPWM_ADR_MASK, 32'h00000000);
        repeat (2) @(posedge clk_i);
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr(`MBPWM_ADR_MASK, 32'h00000002);
        repeat (2) @(posedge clk_i);
        check("irq_unmask", {31'h0, irq}, 32'h1);
        wr(`MBPWM_ADR_STATUS, 32'h00000002);
        repeat (2) @(posedge clk_i);
        check("irq_clr", {31'h0, irq}, 32'h0);
        rdc("status_clr", `MBPWM_ADR_STATUS, 32'h00000000);
        // Stop on match three, no flag asked for
        wr(8'h2C, 32'h00000005);
        wr(`MBPWM_ADR_MCTRL, 32'h00000802);
        wr(`MBPWM_ADR_COUNT, 32'h00000000);
        wr(`MBPWM_ADR_CTRL, 32'h00000001);
        repeat (20) @(posedge clk_i);
        rdc("ctrl_stop", `MBPWM_ADR_CTRL, 32'h00000000);
        rdc("status_stop", `MBPWM_ADR_STATUS, 32'h00000000);
        wb(1'b0, `MBPWM_ADR_COUNT, 32'h00000000, rd);
        repeat (5) @(posedge clk_i);
        rdc("count_held", `MBPWM_ADR_COUNT, rd);
        check("count_near", {31'h0, rd < 7 && rd > 4}, 32'h1);
        wr(`MBPWM_ADR_CTRL, 32'h00000003);
        rdc("count_hold", `MBPWM_ADR_COUNT, 32'h00000000);
        tally_and_finish();
    end
endmodule
